// *** hdl/pls_defs.svh ***
// Constants of the link status block: offsets, fields, resets, timing.
// Assumes pclk at 50 MHz; users include it by its bare name.
// Notes on behaviour
// - Scheme two: gig colour1, fast colour2, ten link colour3, collision colour3.
// - Scheme two ten/duplex pair: off, colour1, off/colour2 or colour1/colour2.
// - Colour three is the two colours alternated at half-and-half duty.
// - In two-colour schemes activity blinks the duplex lamp colour.
// - Scheme three: speed lamp steady on, blinking during activity.
// - Scheme three: duplex lamp on for full duplex, off for half.
// - Isolate ignores transmit data, enable and error; registers still answer.
// - Isolate control bit resets to zero.
// - Carrier from receive only in repeater or full duplex, else either.
// - Carrier starts on two non-adjacent zeros within any ten bits.
// - Ten ones before the start delimiter pair end carrier.
// - Carrier ends on T/R or two idles; T without R, idle then data keep.
// - Collision is simultaneous transmit and receive in half duplex only.
// - Collision test: collision follows transmit enable within bounds.
// - At 10 Mb/s half duplex a 1 us collision pulse starts 2 us after transmit ends.
// - Negotiation done sets a status bit, signals an event, reports speed.
// - Failed negotiation flags parallel detect or master/slave fault.
// - Gigabit link needs both trainings done, stays up on valid symbols.
// - Link breaker counts idle errors per window, drops link over threshold.
// - 10 Mb/s sends a pulse every 16 ms, expects one every 8 to 24 ms.
// - Link drops and transmission stops when pulses or valid idles cease.
// - With negotiation enabled a dropped link renegotiates sending FLPs.
// - Without negotiation a dropped link sends NLPs, MLT-3 idle or trained gigabit idle, by forced speed.
// - Duplex lamp follows resolved duplex early; speed lamps need link.
// - Two-bit scheme field, default three; scheme one swaps speed colours.
`ifndef PLS_DEFS_SVH
`define PLS_DEFS_SVH
`define PLS_CLK_MHZ 50
`define PLS_SQE_DLY_NS 2000
`define PLS_SQE_LEN_NS 1000
`define PLS_NLP_TX_MS 16
`define PLS_NLP_MIN_MS 8
`define PLS_NLP_MAX_MS 24
`define PLS_BREAK_WIN 1000000
`define PLS_ALT_BIT 9
`define PLS_BLINK_BIT 21
`define PLS_OFF_CTRL 8'h00
`define PLS_OFF_STAT 8'h04
`define PLS_OFF_EVT 8'h08
`define PLS_CTRL_RST 32'h0000_002c
`define PLS_CTRL_MASK 32'h00ff_03ff
`define PLS_C_ISO 0
`define PLS_C_CTEST 1
`define PLS_C_SCH 3:2
`define PLS_C_RPT 4
`define PLS_C_ANEN 5
`define PLS_C_FSPD 7:6
`define PLS_C_FFD 8
`define PLS_C_BRK 9
`define PLS_C_THR 23:16
`define PLS_E_AN 0
`define PLS_E_PD 1
`define PLS_E_MS 2
`define PLS_E_BRK 3
`define PLS_SYM_JK 10'h311
`define PLS_SYM_T 5'h0d
`define PLS_SYM_R 5'h07
`define PLS_SYM_IDLE 5'h1f
`define PLS_ONES_END 4'h9
`define PLS_SYM_LAST 3'h4
`endif

// *** hdl/pls_pkg.sv ***
// Types shared by the link status block and its lamp encoder.
// Assumes nothing beyond a SystemVerilog compiler.
package pls_pkg;
  typedef enum logic [1:0] {SCH_OFF, SCH_ONE, SCH_TWO, SCH_THREE} pls_scheme_e;
  typedef enum logic [1:0] {SPD_10, SPD_100, SPD_1000, SPD_RSV} pls_speed_e;
  typedef enum logic [2:0] {CS_OFF, CS_PRE, CS_DATA, CS_T, CS_I} pls_cs_e;
  typedef enum logic [1:0] {LK_DOWN, LK_NEG, LK_WAIT, LK_UP} pls_link_e;
endpackage : pls_pkg

// *** hdl/pls_lamp_if.sv ***
// Status bundle from the link logic to the lamp encoder.
// Assumes both ends run on pclk.
`timescale 1ns/100ps
interface pls_lamp_if;
  import pls_pkg::*;
  pls_scheme_e scheme;
  pls_speed_e speed;
  logic link_up;
  logic full_dup;
  logic dup_valid;
  logic activity;
  logic collision;
  modport src (output scheme, speed, link_up, full_dup, dup_valid,
    activity, collision);
  modport enc (input scheme, speed, link_up, full_dup, dup_valid,
    activity, collision);
endinterface : pls_lamp_if

// *** hdl/pls_lamp_enc.sv ***
// Lamp encoder: maps link status onto four lamp pins per scheme.
// Assumes the status bundle is synchronous to pclk.
`timescale 1ns/100ps
`include "pls_defs.svh"
module pls_lamp_enc import pls_pkg::*; #(
  parameter int CNT_W = 22
) (
  input wire logic pclk,
  input wire logic presetn,
  pls_lamp_if.enc st,
  output logic gig_speed_lamp,
  output logic fast_speed_lamp,
  output logic ten_speed_lamp,
  output logic duplex_activity_lamp
);
  logic [CNT_W-1:0] cnt_q;
  logic act_q;
  logic col_q;
  logic alt;
  logic blink;
  logic blk_end;
  logic is_g, is_f, is_t, two_col, act_on, dup_on;
  logic c1_sel, c2_sel;
  logic pa_c1, pa_c2, pb_c1, pb_c2;
  logic gig_d, fast_d, ten_d, dup_d;

  // One counter feeds both periods so they stay phase locked
  assign alt = cnt_q[`PLS_ALT_BIT];
  assign blink = cnt_q[`PLS_BLINK_BIT];
  assign blk_end = &cnt_q[`PLS_BLINK_BIT:0];
  assign is_g = st.link_up && st.speed == SPD_1000;
  assign is_f = st.link_up && st.speed == SPD_100;
  assign is_t = st.link_up && st.speed == SPD_10;
  assign two_col = st.scheme == SCH_ONE || st.scheme == SCH_TWO;
  assign act_on = act_q & blink;
  assign dup_on = st.dup_valid & st.full_dup;
  assign c1_sel = (st.scheme == SCH_ONE) ? is_f : is_g;
  assign c2_sel = (st.scheme == SCH_ONE) ? is_g : is_f;
  assign pa_c1 = c1_sel | (is_t & alt);
  assign pa_c2 = c2_sel | (is_t & ~alt);
  // Collision colour overrides the activity blink; scheme one shows none
  assign pb_c1 = (st.scheme == SCH_TWO && col_q) ? alt :
    dup_on & ~act_on;
  assign pb_c2 = (st.scheme == SCH_TWO && col_q) ? ~alt : act_on;
  assign gig_d = two_col ? pa_c1 :
    (st.scheme == SCH_THREE) & is_g & ~act_on;
  assign fast_d = two_col ? pa_c2 :
    (st.scheme == SCH_THREE) & is_f & ~act_on;
  assign ten_d = two_col ? pb_c2 :
    (st.scheme == SCH_THREE) & is_t & ~act_on;
  assign dup_d = two_col ? pb_c1 :
    (st.scheme == SCH_THREE) & dup_on;

  // Activity and collision are held until the current blink period ends
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= '0;
      act_q <= 1'b0;
      col_q <= 1'b0;
      gig_speed_lamp <= 1'b0;
      fast_speed_lamp <= 1'b0;
      ten_speed_lamp <= 1'b0;
      duplex_activity_lamp <= 1'b0;
    end else begin
      cnt_q <= cnt_q + 1'b1;
      act_q <= st.activity | (act_q & ~blk_end);
      col_q <= st.collision | (col_q & ~blk_end);
      gig_speed_lamp <= gig_d;
      fast_speed_lamp <= fast_d;
      ten_speed_lamp <= ten_d;
      duplex_activity_lamp <= dup_d;
    end
  end
endmodule : pls_lamp_enc

// *** hdl/pls_link_status.sv ***
// Link supervision, carrier sense, collision and lamps of the transceiver.
// Assumes an APB master on pclk; PCS and negotiation inputs share pclk,
// transmit enable from the MAC is treated as asynchronous.
`timescale 1ns/100ps
`include "pls_defs.svh"
module pls_link_status import pls_pkg::*; #(
  parameter int unsigned NLP_TX_CYC = `PLS_NLP_TX_MS * `PLS_CLK_MHZ * 1000,
  parameter int unsigned NLP_MIN_CYC = `PLS_NLP_MIN_MS * `PLS_CLK_MHZ * 1000,
  parameter int unsigned NLP_MAX_CYC = `PLS_NLP_MAX_MS * `PLS_CLK_MHZ * 1000,
  parameter int unsigned BREAK_WIN = `PLS_BREAK_WIN,
  parameter int NLP_W = 21,
  parameter int WIN_W = 20,
  parameter int LAMP_CNT_W = 22
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [7:0] txd,
  input wire logic tx_en,
  input wire logic tx_er,
  output logic [7:0] tx_path_data,
  output logic tx_path_en,
  output logic tx_path_er,
  output logic crs,
  output logic col,
  input wire logic rx_bit,
  input wire logic rx_bit_vld,
  input wire logic rx_sym_ok,
  input wire logic rx_idle_err,
  input wire logic an_done,
  input wire logic [1:0] an_speed,
  input wire logic an_full_dup,
  input wire logic pd_fault_in,
  input wire logic ms_fault_in,
  output logic an_event,
  input wire logic loc_train_done,
  input wire logic rem_train_done,
  output logic tx_idle_trained,
  input wire logic nlp_rx,
  output logic nlp_tx,
  output logic flp_tx_en,
  output logic mlt3_idle_en,
  output logic link_up,
  output logic gig_speed_lamp,
  output logic fast_speed_lamp,
  output logic ten_speed_lamp,
  output logic duplex_activity_lamp
);
  // SQE start is a least time, rounded up; its length is nominal
  localparam int SQE_DLY_I =
    (`PLS_SQE_DLY_NS * `PLS_CLK_MHZ + 999) / 1000;
  localparam int SQE_END_I =
    SQE_DLY_I + (`PLS_SQE_LEN_NS * `PLS_CLK_MHZ) / 1000;
  localparam logic [7:0] SQE_DLY = 8'(SQE_DLY_I);
  localparam logic [7:0] SQE_END = 8'(SQE_END_I);
  localparam logic [NLP_W-1:0] NLP_TX_LAST = NLP_W'(NLP_TX_CYC - 1);
  localparam logic [NLP_W-1:0] NLP_MIN = NLP_W'(NLP_MIN_CYC);
  localparam logic [NLP_W-1:0] NLP_MAX = NLP_W'(NLP_MAX_CYC);
  localparam logic [WIN_W-1:0] WIN_LAST = WIN_W'(BREAK_WIN - 1);

  pls_lamp_if lamp_bus ();

  // Register bus
  logic [31:0] ctrl_q, ctrl_d;
  logic [3:0] evt_q, evt_d, evt_set, evt_clr;
  logic [31:0] prdata_d, stat_word;
  logic sel_ctrl, sel_stat, sel_evt, mapped, wr_acc, rd_setup;
  // Control fields
  logic iso, ctest, rpt, an_en, brk_en;
  logic [7:0] thr;
  // Transmit enable synchroniser
  logic txen_s1_q, txen_s2_q, txen_s3_q, txen_q, tx_act, tx_act_q;
  // Carrier sense
  pls_cs_e cs_q, cs_d;
  logic [8:0] hist_q;
  logic [9:0] win;
  logic [3:0] ones_q, ones_d;
  logic [2:0] ph_q, ph_d;
  logic rx_car, two_zero, sym_end;
  logic [4:0] sym;
  // Collision
  logic [7:0] sqe_cnt_q, sqe_cnt_d;
  logic sqe_on, coll, tx_fall;
  // Link
  pls_link_e lk_q, lk_d;
  pls_speed_e spd_q, spd_d;
  logic fd_q, fd_d, dv_q, dv_d;
  logic [NLP_W-1:0] ntx_q, ngap_q;
  logic [WIN_W-1:0] win_q;
  logic [8:0] err_q;
  logic is_10, is_100, is_1000, lk_live, nlp_ok, nlp_tmo;
  logic brk_run, brk_trip, up_ok, drop, an_ok, an_bad;

  // APB decode: zero wait, read data captured in the setup cycle
  assign sel_ctrl = paddr == `PLS_OFF_CTRL;
  assign sel_stat = paddr == `PLS_OFF_STAT;
  assign sel_evt = paddr == `PLS_OFF_EVT;
  assign mapped = sel_ctrl | sel_stat | sel_evt;
  assign wr_acc = psel & penable & pwrite & mapped;
  assign rd_setup = psel & ~penable & ~pwrite;
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~mapped;
  assign ctrl_d = (wr_acc && sel_ctrl) ?
    (pwdata & `PLS_CTRL_MASK) : ctrl_q;
  assign stat_word = {24'h000000, brk_en, col, crs, dv_q, fd_q, spd_q,
    lk_q == LK_UP};
  assign prdata_d = !rd_setup ? prdata :
    sel_ctrl ? ctrl_q :
    sel_stat ? stat_word :
    sel_evt ? {28'h0000000, evt_q} : 32'h0000_0000;
  // Event flags clear on writing one; a set in the same cycle wins
  assign evt_clr = (wr_acc && sel_evt) ? pwdata[3:0] : 4'h0;
  assign evt_set = {brk_trip, an_bad & ms_fault_in,
    an_bad & pd_fault_in, an_ok};
  assign evt_d = (evt_q & ~evt_clr) | evt_set;

  assign iso = ctrl_q[`PLS_C_ISO];
  assign ctest = ctrl_q[`PLS_C_CTEST];
  assign rpt = ctrl_q[`PLS_C_RPT];
  assign an_en = ctrl_q[`PLS_C_ANEN];
  assign brk_en = ctrl_q[`PLS_C_BRK];
  assign thr = ctrl_q[`PLS_C_THR];

  // Isolation only gates the MAC side; the register bus keeps working
  assign tx_act = txen_q & ~iso;
  assign tx_fall = tx_act_q & ~tx_act;

  // Carrier detection on the unscrambled code bit stream
  assign win = {hist_q, rx_bit};
  assign two_zero = ~rx_bit & ~(&hist_q[8:1]);
  assign sym = win[4:0];
  assign sym_end = ph_q == `PLS_SYM_LAST;
  assign rx_car = cs_q == CS_PRE || cs_q == CS_DATA;
  assign ones_d = !rx_bit_vld ? ones_q :
    !rx_bit ? 4'h0 :
    (ones_q == `PLS_ONES_END) ? ones_q : ones_q + 4'h1;

  always_comb begin
    cs_d = cs_q;
    ph_d = ph_q;
    if (rx_bit_vld) begin
      ph_d = sym_end ? 3'h0 : ph_q + 3'h1;
      case (cs_q)
        CS_OFF: begin
          if (two_zero) begin
            cs_d = CS_PRE;
          end
        end
        CS_PRE: begin
          if (win == `PLS_SYM_JK) begin
            cs_d = CS_DATA;
            ph_d = 3'h0;
          end else if (rx_bit && ones_q == `PLS_ONES_END) begin
            cs_d = CS_OFF;
          end
        end
        CS_DATA: begin
          if (sym_end && sym == `PLS_SYM_T) begin
            cs_d = CS_T;
          end else if (sym_end && sym == `PLS_SYM_IDLE) begin
            cs_d = CS_I;
          end
        end
        CS_T: begin
          if (sym_end) begin
            cs_d = (sym == `PLS_SYM_R) ? CS_OFF : CS_DATA;
          end
        end
        CS_I: begin
          if (sym_end) begin
            cs_d = (sym == `PLS_SYM_IDLE) ? CS_OFF : CS_DATA;
          end
        end
        default: cs_d = CS_OFF;
      endcase
    end
  end

  // Collision is left combinational so it follows its causes directly
  assign coll = ~fd_q & tx_act & rx_car;
  assign sqe_on = is_10 && !fd_q && sqe_cnt_q >= SQE_DLY &&
    sqe_cnt_q < SQE_END;
  assign col = coll | (ctest & tx_act) | sqe_on;
  assign sqe_cnt_d = tx_fall ? 8'h01 :
    (sqe_cnt_q != 8'h00 && sqe_cnt_q < SQE_END) ?
    sqe_cnt_q + 8'h01 : 8'h00;

  // Link supervision
  assign is_10 = spd_q == SPD_10;
  assign is_100 = spd_q == SPD_100;
  assign is_1000 = spd_q == SPD_1000;
  assign lk_live = lk_q == LK_WAIT || lk_q == LK_UP;
  assign nlp_ok = nlp_rx && (ngap_q >= NLP_MIN || lk_q != LK_UP);
  assign nlp_tmo = ngap_q >= NLP_MAX;
  assign brk_run = brk_en && is_1000 && lk_q == LK_UP;
  assign brk_trip = brk_run && err_q > {1'b0, thr};
  assign an_ok = lk_q == LK_NEG && an_done && !pd_fault_in && !ms_fault_in;
  assign an_bad = lk_q == LK_NEG && an_done && (pd_fault_in | ms_fault_in);
  assign up_ok = is_1000 ? (loc_train_done & rem_train_done) :
    is_100 ? rx_sym_ok : nlp_ok;
  assign drop = is_10 ? nlp_tmo : (~rx_sym_ok | brk_trip);

  always_comb begin
    lk_d = lk_q;
    spd_d = spd_q;
    fd_d = fd_q;
    dv_d = dv_q;
    case (lk_q)
      LK_DOWN: begin
        if (an_en) begin
          lk_d = LK_NEG;
          dv_d = 1'b0;
        end else begin
          lk_d = LK_WAIT;
          spd_d = pls_speed_e'(ctrl_q[`PLS_C_FSPD]);
          fd_d = ctrl_q[`PLS_C_FFD];
          dv_d = 1'b1;
        end
      end
      LK_NEG: begin
        if (an_ok) begin
          lk_d = LK_WAIT;
          spd_d = pls_speed_e'(an_speed);
          fd_d = an_full_dup;
          dv_d = 1'b1;
        end
      end
      LK_WAIT: begin
        if (up_ok) begin
          lk_d = LK_UP;
        end
      end
      LK_UP: begin
        if (drop) begin
          lk_d = LK_DOWN;
        end
      end
      default: lk_d = LK_DOWN;
    endcase
  end

  // Link outputs; data transmission is cut whenever the link is down
  assign link_up = lk_q == LK_UP;
  assign flp_tx_en = lk_q == LK_NEG;
  assign mlt3_idle_en = is_100 & lk_live;
  assign tx_idle_trained = is_1000 & lk_live & loc_train_done;
  assign nlp_tx = is_10 && lk_live && ntx_q == NLP_TX_LAST;

  assign lamp_bus.scheme = pls_scheme_e'(ctrl_q[`PLS_C_SCH]);
  assign lamp_bus.speed = spd_q;
  assign lamp_bus.link_up = link_up;
  assign lamp_bus.full_dup = fd_q;
  assign lamp_bus.dup_valid = dv_q;
  assign lamp_bus.activity = tx_act | rx_car;
  assign lamp_bus.collision = coll;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= `PLS_CTRL_RST;
      evt_q <= 4'h0;
      prdata <= 32'h0000_0000;
      an_event <= 1'b0;
    end else begin
      ctrl_q <= ctrl_d;
      evt_q <= evt_d;
      prdata <= prdata_d;
      an_event <= an_ok;
    end
  end

  // The first stage feeds only the second
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      txen_s1_q <= 1'b0;
      txen_s2_q <= 1'b0;
      txen_s3_q <= 1'b0;
      txen_q <= 1'b0;
      tx_act_q <= 1'b0;
      sqe_cnt_q <= 8'h00;
      crs <= 1'b0;
    end else begin
      txen_s1_q <= tx_en;
      txen_s2_q <= txen_s1_q;
      txen_s3_q <= txen_s2_q;
      if (txen_s2_q == txen_s3_q) begin
        txen_q <= txen_s3_q;
      end
      tx_act_q <= tx_act;
      sqe_cnt_q <= sqe_cnt_d;
      crs <= rx_car | (tx_act & ~(fd_q | rpt));
    end
  end

  // Data path stays on the MAC's timing, gated by isolation and link
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_path_data <= 8'h00;
      tx_path_en <= 1'b0;
      tx_path_er <= 1'b0;
    end else begin
      tx_path_data <= (iso || !link_up) ? 8'h00 : txd;
      tx_path_en <= tx_en & ~iso & link_up;
      tx_path_er <= tx_er & ~iso & link_up;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cs_q <= CS_OFF;
      hist_q <= 9'h1ff;
      ones_q <= 4'h0;
      ph_q <= 3'h0;
    end else begin
      cs_q <= cs_d;
      ph_q <= ph_d;
      ones_q <= ones_d;
      if (rx_bit_vld) begin
        hist_q <= win[8:0];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lk_q <= LK_DOWN;
      spd_q <= SPD_10;
      fd_q <= 1'b0;
      dv_q <= 1'b0;
    end else begin
      lk_q <= lk_d;
      spd_q <= spd_d;
      fd_q <= fd_d;
      dv_q <= dv_d;
    end
  end

  // Pulse timers run only while a 10 Mb/s link is attempted or up
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ntx_q <= '0;
      ngap_q <= '0;
    end else if (!(is_10 && lk_live)) begin
      ntx_q <= '0;
      ngap_q <= '0;
    end else begin
      ntx_q <= (ntx_q == NLP_TX_LAST) ? '0 : ntx_q + 1'b1;
      if (nlp_ok) begin
        ngap_q <= '0;
      end else if (!nlp_tmo) begin
        ngap_q <= ngap_q + 1'b1;
      end
    end
  end

  // Idle errors are counted per fixed window, saturating
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      win_q <= '0;
      err_q <= 9'h000;
    end else if (!brk_run || win_q == WIN_LAST) begin
      win_q <= '0;
      err_q <= 9'h000;
    end else begin
      win_q <= win_q + 1'b1;
      if (rx_idle_err && err_q != 9'h1ff) begin
        err_q <= err_q + 9'h001;
      end
    end
  end

  pls_lamp_enc #(
    .CNT_W(LAMP_CNT_W)
  ) u_lamp (
    .pclk(pclk),
    .presetn(presetn),
    .st(lamp_bus.enc),
    .gig_speed_lamp(gig_speed_lamp),
    .fast_speed_lamp(fast_speed_lamp),
    .ten_speed_lamp(ten_speed_lamp),
    .duplex_activity_lamp(duplex_activity_lamp)
  );
endmodule : pls_link_status

// *** test/pls_far_end.sv ***
// Far end model: link partner as seen at the PCS status inputs.
// Assumes pclk is shared with the block; spd 0=10, 1=100, 2=1000.
`timescale 1ns/100ps
module pls_far_end (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic en,
  input wire logic [1:0] spd,
  output logic rx_sym_ok,
  output logic loc_train_done,
  output logic rem_train_done,
  output logic nlp_rx
);
  logic [5:0] nlp_q;
  logic [3:0] trn_q;
  // Pulses 40 cycles apart sit well inside the accepted window
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      nlp_q <= 6'h00;
      trn_q <= 4'h0;
    end else begin
      nlp_q <= (en && spd == 2'h0 && nlp_q != 6'h27) ? nlp_q + 6'h01 : 6'h00;
      trn_q <= (en && spd == 2'h2) ? trn_q + {3'h0, trn_q != 4'hf} : 4'h0;
    end
  end
  assign nlp_rx = (nlp_q == 6'h27);
  // Remote training ends later, so link must wait for both sides
  assign loc_train_done = (trn_q >= 4'h4);
  assign rem_train_done = (trn_q >= 4'h8);
  assign rx_sym_ok = en && spd != 2'h0;
endmodule : pls_far_end

// *** test/pls_link_status_assertions.sv ***
// Checker of the link status block, seeing only its top ports.
// Assumes pclk is the only clock and presetn its async reset.
`timescale 1ns/100ps
module pls_link_status_chk (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [7:0] txd,
  input wire logic tx_en,
  input wire logic [7:0] tx_path_data,
  input wire logic tx_path_en,
  input wire logic tx_path_er,
  input wire logic col,
  input wire logic an_done,
  input wire logic pd_fault_in,
  input wire logic ms_fault_in,
  input wire logic an_event,
  input wire logic link_up,
  input wire logic flp_tx_en
);
  logic iso_q, ct_q, an_q;
  wire logic ctrl_wr = psel && penable && pwrite && paddr == 8'h00;
  // Shadow of the control bits, since only ports are visible here
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      iso_q <= 1'b0;
      ct_q <= 1'b0;
      an_q <= 1'b1;
    end else if (ctrl_wr) begin
      iso_q <= pwdata[0];
      ct_q <= pwdata[1];
      an_q <= pwdata[5];
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  iso_gate_a: assert property (
    iso_q && $past(iso_q) |-> !tx_path_en) else $error("path open");
  path_pass_a: assert property (
    $past(link_up) && !$past(iso_q) |-> tx_path_data == $past(txd))
    else $error("path data wrong");
  down_stop_a: assert property (
    !$past(link_up) |-> {tx_path_en, tx_path_er, tx_path_data} == 10'h000)
    else $error("path live without link");
  an_evt_a: assert property (
    an_done && flp_tx_en && !pd_fault_in && !ms_fault_in |=>
    an_event ##1 !an_event) else $error("no event");
  ctest_on_a: assert property (
    ct_q && $rose(tx_en) |-> ##[1:8] col) else $error("test col late");
  ctest_off_a: assert property (
    ct_q && $fell(tx_en) |-> ##[1:8] !col) else $error("test col stuck");
  flp_after_a: assert property (
    $fell(link_up) && an_q |-> ##[1:3] flp_tx_en) else $error("no renegotiate");
  flp_need_an_a: assert property (
    $rose(flp_tx_en) |-> $past(an_q)) else $error("no negotiation");
endmodule : pls_link_status_chk

// *** test/test_phy_link_status_indicators.sv ***
// Bench of the link status block: APB master, MAC side and far end.
// Assumes the far end model and the checker are compiled first.
`timescale 1ns/100ps
module test_phy_link_status_indicators;
  logic pclk, presetn, psel, penable, pwrite, tx_en, an_done, an_full_dup;
  logic rx_bit, rx_bit_vld, far_en, err, pslverr, pready, crs, col, nlp_rx;
  logic an_event, flp_tx_en, link_up, loc_train_done, rem_train_done;
  logic gig_speed_lamp, fast_speed_lamp, ten_speed_lamp, duplex_activity_lamp;
  logic tx_path_en, tx_path_er, rx_sym_ok, tx_er, flt, idle_err;
  logic [1:0] an_speed, far_spd;
  logic [7:0] paddr, txd, tx_path_data;
  logic [31:0] pwdata, prdata, rd;
  // Rows: speed, full duplex, expected gig/fast/ten/duplex lamps
  logic [6:0] rows [3] = '{7'h13, 7'h24, 7'h59};
  int mismatches, cmp_count, cyc, n, k, z;
  wire logic [3:0] lamps = {gig_speed_lamp, fast_speed_lamp, ten_speed_lamp,
    duplex_activity_lamp};
  pls_link_status #(.NLP_TX_CYC(40), .NLP_MIN_CYC(20), .NLP_MAX_CYC(60),
    .NLP_W(8), .BREAK_WIN(64)) DUT (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .txd(txd), .tx_en(tx_en), .tx_er(tx_er), .tx_path_data(tx_path_data),
    .tx_path_en(tx_path_en), .tx_path_er(tx_path_er), .crs(crs), .col(col),
    .rx_bit(rx_bit), .rx_bit_vld(rx_bit_vld), .rx_sym_ok(rx_sym_ok),
    .rx_idle_err(idle_err), .an_done(an_done), .an_speed(an_speed),
    .an_full_dup(an_full_dup), .pd_fault_in(flt), .ms_fault_in(flt),
    .an_event(an_event), .loc_train_done(loc_train_done),
    .rem_train_done(rem_train_done), .tx_idle_trained(), .nlp_rx(nlp_rx),
    .nlp_tx(), .flp_tx_en(flp_tx_en), .mlt3_idle_en(), .link_up(link_up),
    .gig_speed_lamp(gig_speed_lamp), .fast_speed_lamp(fast_speed_lamp),
    .ten_speed_lamp(ten_speed_lamp),
    .duplex_activity_lamp(duplex_activity_lamp));
  pls_far_end u_far (.pclk(pclk), .presetn(presetn), .en(far_en),
    .spd(far_spd), .rx_sym_ok(rx_sym_ok), .loc_train_done(loc_train_done),
    .rem_train_done(rem_train_done), .nlp_rx(nlp_rx));
  task end_sim();
    if (mismatches == 0 && cmp_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : end_sim
  task chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task sym(input logic [9:0] v);
    for (int b = 9; b >= 0; b--) begin
      rx_bit <= v[b];
      rx_bit_vld <= 1'b1;
      @(posedge pclk);
    end
  endtask : sym
  task up(input logic [1:0] s, input logic f);
    while (flp_tx_en !== 1'b1) @(posedge pclk);
    an_done <= 1'b1;
    an_speed <= s;
    an_full_dup <= f;
    @(posedge pclk);
    an_done <= 1'b0;
    repeat (4) @(posedge pclk);
    chk(lamps, {3'h0, f});
    far_spd <= s;
    far_en <= 1'b1;
    while (link_up !== 1'b1) @(posedge pclk);
    repeat (4) @(posedge pclk);
  endtask : up
  task down();
    far_en <= 1'b0;
    while (link_up !== 1'b0) @(posedge pclk);
    repeat (3) @(posedge pclk);
    chk(flp_tx_en, 1'b1);
  endtask : down
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  // Hang guard: the whole sequence needs well under 5000 cycles
  always @(posedge pclk) begin
    cyc++;
    if (cyc > 10000) begin
      mismatches++;
      end_sim();
    end
  end
  initial begin
    {psel, penable, pwrite, tx_en, an_done, an_full_dup} = 6'h00;
    {rx_bit_vld, far_en, presetn, an_speed, far_spd} = 7'h00;
    {paddr, txd, pwdata} = 48'h0;
    rx_bit = 1'b1;
    {tx_er, flt, idle_err} = 3'h0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, 8'h00, 32'h0);
    chk(rd, 32'h0000_002c);
    apb(1'b0, 8'h0c, 32'h0);
    chk(err, 1'b1);
    chk(rd, 32'h0);
    for (int i = 0; i < 3; i++) begin
      up(rows[i][6:5], rows[i][4]);
      chk(lamps, rows[i][3:0]);
      apb(1'b0, 8'h04, 32'h0);
      chk(rd[4:0], {1'b1, rows[i][4], rows[i][6:5], 1'b1});
      apb(1'b0, 8'h08, 32'h0);
      chk(rd[0], 1'b1);
      apb(1'b1, 8'h08, 32'h1);
      down();
    end
    // Lamp duty first: later activity stretches the blink for long
    apb(1'b1, 8'h00, 32'h28);
    up(2'h0, 1'b0);
    repeat (2048) begin
      @(posedge pclk);
      n += gig_speed_lamp;
      k += gig_speed_lamp ^ fast_speed_lamp;
      z += ten_speed_lamp | duplex_activity_lamp;
    end
    chk(n, 32'h400);
    chk(k, 32'h800);
    chk(z, 32'h0);
    tx_en <= 1'b1;
    repeat (8) @(posedge pclk);
    chk(crs, 1'b1);
    chk(col, 1'b0);
    tx_en <= 1'b0;
    n = 0;
    k = 0;
    for (int c = 1; c < 200; c++) begin
      @(posedge pclk);
      n += col;
      if (col === 1'b1 && k == 0) k = c;
    end
    chk(n, 32'h32);
    chk(k > 100 && k < 108, 1'b1);
    apb(1'b1, 8'h00, 32'h2a);
    tx_en <= 1'b1;
    repeat (10) @(posedge pclk);
    chk(col, 1'b1);
    tx_en <= 1'b0;
    repeat (200) @(posedge pclk);
    apb(1'b1, 8'h00, 32'h2c);
    down();
    up(2'h1, 1'b1);
    txd <= 8'ha5;
    {tx_en, tx_er} <= 2'h3;
    sym(10'h3ff);
    sym(10'h311);
    sym(10'h1ce);
    chk(crs, 1'b1);
    chk({tx_path_er, tx_path_en, tx_path_data}, 32'h3a5);
    sym(10'h1a7);
    sym(10'h3ff);
    rx_bit_vld <= 1'b0;
    repeat (3) @(posedge pclk);
    chk(crs, 1'b0);
    apb(1'b1, 8'h00, 32'h2d);
    repeat (2) @(posedge pclk);
    chk({tx_path_er, tx_path_en, tx_path_data}, 32'h0);
    apb(1'b0, 8'h00, 32'h0);
    chk(rd, 32'h2d);
    {tx_en, tx_er} <= 2'h0;
    down();
    // A faulted negotiation must leave the link negotiating
    flt <= 1'b1;
    an_done <= 1'b1;
    @(posedge pclk);
    {an_done, flt} <= 2'h0;
    chk(flp_tx_en, 1'b1);
    apb(1'b1, 8'h00, 32'h22c);
    up(2'h2, 1'b0);
    idle_err <= 1'b1;
    repeat (4) @(posedge pclk);
    chk(link_up, 1'b0);
    idle_err <= 1'b0;
    apb(1'b0, 8'h08, 32'h0);
    chk(rd[3:1], 3'h7);
    down();
    end_sim();
  end
endmodule : test_phy_link_status_indicators
bind pls_link_status pls_link_status_chk u_chk (.pclk(pclk),
  .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .txd(txd), .tx_en(tx_en),
  .tx_path_data(tx_path_data), .tx_path_en(tx_path_en),
  .tx_path_er(tx_path_er), .col(col), .an_done(an_done),
  .an_event(an_event), .link_up(link_up), .flp_tx_en(flp_tx_en),
  .pd_fault_in(pd_fault_in), .ms_fault_in(ms_fault_in));
